// *** rtl/pad_config_and_gpio_port.sv ***
// pad configuration and 12-bit general-purpose port for one device port
// assumes peripherals present their own output and enable; all controls are plain ports
`timescale 1ns/1ps

module pad_config_and_gpio_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_we,
  input wire logic [3:0] cfg_pin,
  input wire pad_port_pkg::pin_cfg_s cfg_wdata,
  input wire logic sink_we,
  input wire logic [pad_port_pkg::SINK_WIDTH-1:0] sink_current_low_level,
  input wire logic [pad_port_pkg::SINK_WIDTH-1:0] sink_current_high_level,
  input wire pad_port_pkg::out_req_s out_req,
  input wire pad_port_pkg::dir_op_e dir_op,
  input wire logic [pad_port_pkg::PIN_COUNT-1:0] dir_bits,
  input wire logic deep_power_down,
  input wire logic [pad_port_pkg::PIN_COUNT-1:0] periph_out,
  input wire logic [pad_port_pkg::PIN_COUNT-1:0] periph_oe,
  input wire logic [pad_port_pkg::PIN_COUNT-1:0] pad_in,
  output logic [pad_port_pkg::PIN_COUNT-1:0] pad_out,
  output logic [pad_port_pkg::PIN_COUNT-1:0] pad_oe,
  output pad_port_pkg::pad_ctl_s [pad_port_pkg::PIN_COUNT-1:0] pad_ctl,
  output logic [pad_port_pkg::SINK_WIDTH-1:0] sink_level,
  output logic [pad_port_pkg::PIN_COUNT-1:0] port_read,
  output logic [pad_port_pkg::PIN_COUNT-1:0] periph_in,
  output logic [pad_port_pkg::PIN_COUNT-1:0] port_direction_reg,
  output logic [pad_port_pkg::PIN_COUNT-1:0] port_out_reg,
  output pad_port_pkg::pin_cfg_s [pad_port_pkg::PIN_COUNT-1:0] pad_config_block
);

  localparam int N = pad_port_pkg::PIN_COUNT;

  function automatic pad_port_pkg::pin_cfg_s reset_cfg(input int idx);
    if (idx == pad_port_pkg::BUS_PAD_A || idx == pad_port_pkg::BUS_PAD_B) begin
      return pad_port_pkg::BUS_CFG_RESET;
    end else if (idx == pad_port_pkg::DEBUG_PAD_A || idx == pad_port_pkg::DEBUG_PAD_B) begin
      return pad_port_pkg::DEBUG_CFG_RESET;
    end
    return pad_port_pkg::PIN_CFG_RESET;
  endfunction

  function automatic logic is_bus_pad(input int idx);
    return idx == pad_port_pkg::BUS_PAD_A || idx == pad_port_pkg::BUS_PAD_B;
  endfunction

  pad_port_pkg::pin_cfg_s [N-1:0] cfg_q;
  logic [N-1:0] dir_q;
  logic [N-1:0] dir_d;
  logic [N-1:0] out_q;
  logic [N-1:0] out_d;
  logic [pad_port_pkg::SINK_WIDTH-1:0] sink_lo_q;
  logic [pad_port_pkg::SINK_WIDTH-1:0] sink_hi_q;
  logic [N-1:0] level;
  logic [N-1:0] is_port;
  logic [N-1:0] drive_oe;
  logic [N-1:0] drive_val;
  logic [N-1:0] pin_sel;
  logic [N-1:0] keep_q;
  logic cfg_in_range;

  assign cfg_in_range = cfg_pin < 4'(N);

  // direction updates act only on the selected bits
  always_comb begin
    unique case (dir_op)
      pad_port_pkg::DIR_OP_NONE: dir_d = dir_q;
      pad_port_pkg::DIR_OP_SET: dir_d = dir_q | dir_bits;
      pad_port_pkg::DIR_OP_CLEAR: dir_d = dir_q & ~dir_bits;
      pad_port_pkg::DIR_OP_TOGGLE: dir_d = dir_q ^ dir_bits;
    endcase
  end

  // every output form lands in the same edge
  always_comb begin
    case (out_req.op)
      pad_port_pkg::OUT_OP_WRITE: out_d = out_req.data;
      pad_port_pkg::OUT_OP_MASKED: out_d = (out_q & ~out_req.mask) |
                                           (out_req.data & out_req.mask);
      pad_port_pkg::OUT_OP_SET: out_d = out_q | out_req.data;
      pad_port_pkg::OUT_OP_CLEAR: out_d = out_q & ~out_req.data;
      default: out_d = out_q;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dir_q <= '0;
      out_q <= '0;
      sink_lo_q <= pad_port_pkg::SINK_LO_RESET;
      sink_hi_q <= pad_port_pkg::SINK_HI_RESET;
    end else begin
      dir_q <= dir_d;
      out_q <= out_d;
      if (sink_we) begin
        sink_lo_q <= sink_current_low_level;
        sink_hi_q <= sink_current_high_level;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      pad_port_pkg::pin_cfg_s c;
      logic rep;
      logic sink_ok;

      assign pin_sel[g] = cfg_we && cfg_in_range && cfg_pin == 4'(g);

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          cfg_q[g] <= reset_cfg(g);
          keep_q[g] <= 1'b0;
        end else begin
          if (pin_sel[g]) begin
            cfg_q[g] <= cfg_wdata;
          end
          // keeper follows the last sensed level unless power is gone
          if (!deep_power_down) begin
            keep_q[g] <= level[g];
          end
        end
      end

      assign c = cfg_q[g];
      assign is_port[g] = c.pin_function_select == pad_port_pkg::PIN_FUNCTION_SELECT_PORT;
      assign rep = c.res_mode == pad_port_pkg::RES_REPEATER;
      assign sink_ok = pad_port_pkg::HIGH_SOURCE_MASK[g];

      // fixed wiring: port bit g only ever reaches pin g
      assign drive_oe[g] = is_port[g] ? dir_q[g] : periph_oe[g];
      assign drive_val[g] = is_port[g] ? out_q[g] : periph_out[g];

      pin_input_filter pin_input_filter_inst (
        .clk(clk),
        .reset(reset),
        .pad_in(pad_in[g]),
        .filter_en(c.lowpass),
        .level(level[g])
      );

      // i2c pads pull low only and release a high to the wire; sink-mode high-source pads turn the push-pull drive off
      if (is_bus_pad(g)) begin : g_od
        assign pad_out[g] = 1'b0;
        assign pad_oe[g] = drive_oe[g] && !drive_val[g];
      end else begin : g_pp
        assign pad_out[g] = drive_val[g];
        assign pad_oe[g] = drive_oe[g] && !(sink_ok && c.sink_mode);
      end

      assign pad_ctl[g].pull_up = (c.res_mode == pad_port_pkg::RES_PULL_UP) ||
                                  (rep && keep_q[g] && !deep_power_down);
      assign pad_ctl[g].pull_down = (c.res_mode == pad_port_pkg::RES_PULL_DOWN) ||
                                    (rep && !keep_q[g] && !deep_power_down);
      assign pad_ctl[g].open_drain = is_bus_pad(g);
      // filtered standard/fast pad unless plain open-drain is chosen
      assign pad_ctl[g].glitch_filter = is_bus_pad(g) && !is_port[g] &&
                                        !c.i2c_plain;
      assign pad_ctl[g].hysteresis = c.hysteresis;
      assign pad_ctl[g].input_enable = c.input_digital;
      assign pad_ctl[g].sink_enable = sink_ok && c.sink_mode && drive_oe[g];

      assign port_read[g] = c.input_digital ? level[g] : 1'b0;
      assign periph_in[g] = is_port[g] ? 1'b0 : level[g];
    end
  endgenerate

  // shared sink level goes high when the driven value of any high-source pad is 1, in sink mode or not
  localparam logic [N-1:0] HS_VAL = pad_port_pkg::HIGH_SOURCE_MASK;
  logic sink_high;
  assign sink_high = |(HS_VAL & drive_val);
  assign sink_level = sink_high ? sink_hi_q : sink_lo_q;

  assign port_direction_reg = dir_q;
  assign port_out_reg = out_q;
  assign pad_config_block = cfg_q;

endmodule

// *** rtl/pad_port_pkg.sv ***
// constants, field layouts and carrier structs for the pad configuration and port block
// assumes a single system clock; the package is referenced by full scope, never imported
//
// Contract
// - a pin belongs to the general-purpose port when its function field is 000, any other code hands it to a peripheral.
// - a port-owned pin drives or listens according to its bit in the port direction register.
// - a peripheral-owned pin takes its direction from the peripheral and ignores the port direction register.
// - each pin has a resistor mode of pull-up, pull-down, none or repeater.
// - after reset every resistor mode is none; the code resets the two debug pads to pull-up.
// - repeater mode enables the pull-up while the pin reads 1 and the pull-down while it reads 0, holding the last level.
// - repeater retention need not hold in the deepest power-down state.
// - on the two bus pads the I2C function offers a filtered standard/fast pad or an unfiltered open-drain pad.
// - each of the four high-source pads is either digital or a current sink switching between low and high levels.
// - each pin also configures input mode, hysteresis, an optional low-pass filter and a bus keeper.
// - masked set and clear writes change any chosen output bits in one write and leave the others alone.
// - a whole-port write updates all output bits together in one transfer.
// - every port access completes in the same single cycle.
// - after reset all pins are port inputs with no pull, except the two bus pads and the two debug pads.
// - each direction bit can be set, cleared or toggled without disturbing the others.
// - each port bit is wired to one fixed pin and is only enabled or disabled there.
package pad_port_pkg;

  localparam int PIN_COUNT = 12;
  localparam int PIN_FUNCTION_SELECT_WIDTH = 3;
  localparam int SINK_WIDTH = 4;
  localparam int FILT_DEPTH = 3;

  localparam logic [PIN_FUNCTION_SELECT_WIDTH-1:0] PIN_FUNCTION_SELECT_PORT = 3'h0;
  localparam logic [PIN_FUNCTION_SELECT_WIDTH-1:0] PIN_FUNCTION_SELECT_ALT1 = 3'h1;

  // fixed pin indices of the special pads
  localparam int BUS_PAD_A = 4;
  localparam int BUS_PAD_B = 5;
  localparam int HIGH_SOURCE_PAD_A = 3;
  localparam int HIGH_SOURCE_PAD_B = 7;
  localparam int DEBUG_PAD_A = 10;
  localparam int DEBUG_PAD_B = 11;
  localparam logic [PIN_COUNT-1:0] HIGH_SOURCE_MASK = 12'hC88;

  typedef enum logic [1:0] {
    RES_NONE = 2'h0,
    RES_PULL_DOWN = 2'h1,
    RES_PULL_UP = 2'h2,
    RES_REPEATER = 2'h3
  } res_mode_e;

  typedef enum logic [1:0] {
    DIR_OP_NONE = 2'h0,
    DIR_OP_SET = 2'h1,
    DIR_OP_CLEAR = 2'h2,
    DIR_OP_TOGGLE = 2'h3
  } dir_op_e;

  typedef enum logic [2:0] {
    OUT_OP_NONE = 3'h0,
    OUT_OP_WRITE = 3'h1,
    OUT_OP_MASKED = 3'h2,
    OUT_OP_SET = 3'h3,
    OUT_OP_CLEAR = 3'h4
  } out_op_e;

  typedef struct packed {
    logic [PIN_FUNCTION_SELECT_WIDTH-1:0] pin_function_select;
    res_mode_e res_mode;
    logic input_digital;
    logic hysteresis;
    logic lowpass;
    logic i2c_plain;
    logic sink_mode;
  } pin_cfg_s;

  // reset values: ordinary pins are port inputs without pulls
  localparam pin_cfg_s PIN_CFG_RESET = '{PIN_FUNCTION_SELECT_PORT, RES_NONE, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  // bus pads come up on the I2C function, debug pads on the debug function with pull-up
  localparam pin_cfg_s BUS_CFG_RESET = '{PIN_FUNCTION_SELECT_ALT1, RES_NONE, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  localparam pin_cfg_s DEBUG_CFG_RESET = '{PIN_FUNCTION_SELECT_ALT1, RES_PULL_UP, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam logic [SINK_WIDTH-1:0] SINK_LO_RESET = 4'h0;
  localparam logic [SINK_WIDTH-1:0] SINK_HI_RESET = 4'hF;

  typedef struct packed {
    out_op_e op;
    logic [PIN_COUNT-1:0] data;
    logic [PIN_COUNT-1:0] mask;
  } out_req_s;

  typedef struct packed {
    logic pull_up;
    logic pull_down;
    logic open_drain;
    logic glitch_filter;
    logic hysteresis;
    logic input_enable;
    logic sink_enable;
  } pad_ctl_s;

endpackage

// *** rtl/pin_input_filter.sv ***
// per-pin input conditioning: three-flop synchroniser plus optional low-pass
// assumes pad input is asynchronous to clk; one instance per pin
`timescale 1ns/1ps

module pin_input_filter (
  input wire logic clk,
  input wire logic reset,
  input wire logic pad_in,
  input wire logic filter_en,
  output logic level
);

  logic [2:0] sync_q;
  logic [pad_port_pkg::FILT_DEPTH-1:0] hist_q;
  logic level_q;
  logic agree;
  logic all_one;
  logic all_zero;

  // only stages 1 and 2 are examined; stage 0 feeds stage 1 alone
  assign agree = sync_q[1] == sync_q[2];
  assign all_one = &hist_q;
  assign all_zero = ~|hist_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_q <= 3'h0;
      hist_q <= '0;
      level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], pad_in};
      if (agree) begin
        hist_q <= {hist_q[pad_port_pkg::FILT_DEPTH-2:0], sync_q[2]};
      end
      // low-pass needs a steady run before a change is accepted
      if (!filter_en && agree) begin
        level_q <= sync_q[2];
      end else if (filter_en && all_one) begin
        level_q <= 1'b1;
      end else if (filter_en && all_zero) begin
        level_q <= 1'b0;
      end
    end
  end

  assign level = level_q;

endmodule

// *** verification/pad_port_checker.sv ***
// concurrent checks on the pad and port block, pin 0 for drive, pin 1 for repeater pulls
// assumes the single clk domain with async active-high reset; bound at the foot
`timescale 1ns/1ps
module pad_port_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_we,
  input wire logic [3:0] cfg_pin,
  input wire pad_port_pkg::pin_cfg_s cfg_wdata,
  input wire pad_port_pkg::out_req_s out_req,
  input wire pad_port_pkg::dir_op_e dir_op,
  input wire logic [11:0] dir_bits,
  input wire logic deep_power_down,
  input wire logic [11:0] periph_out,
  input wire logic [11:0] periph_oe,
  input wire logic [11:0] pad_out,
  input wire logic [11:0] pad_oe,
  input wire pad_port_pkg::pad_ctl_s [11:0] pad_ctl,
  input wire logic [11:0] port_direction_reg,
  input wire logic [11:0] port_out_reg,
  input wire pad_port_pkg::pin_cfg_s [11:0] pad_config_block
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  pad_port_pkg::pin_cfg_s c0;
  assign c0 = pad_config_block[0];
  pad_port_pkg::pin_cfg_s c1;
  assign c1 = pad_config_block[1];
  a_port_pin_drive: assert property (c0.pin_function_select == 3'h0 |-> pad_oe[0] == port_direction_reg[0]
    && (!pad_oe[0] || pad_out[0] == port_out_reg[0])) else $error("port pin drive wrong");
  a_periph_pin_drive: assert property (c0.pin_function_select != 3'h0 |-> pad_oe[0] == periph_oe[0]
    && (!pad_oe[0] || pad_out[0] == periph_out[0])) else $error("peripheral pin drive wrong");
  a_out_whole_write: assert property (out_req.op == pad_port_pkg::OUT_OP_WRITE
    |=> port_out_reg == $past(out_req.data)) else $error("whole write wrong");
  a_out_set_bits: assert property (out_req.op == pad_port_pkg::OUT_OP_SET
    |=> port_out_reg == ($past(port_out_reg) | $past(out_req.data))) else $error("set wrong");
  a_out_clear_bits: assert property (out_req.op == pad_port_pkg::OUT_OP_CLEAR
    |=> port_out_reg == ($past(port_out_reg) & ~$past(out_req.data))) else $error("clear wrong");
  a_out_masked_write: assert property (out_req.op == pad_port_pkg::OUT_OP_MASKED |=>
    port_out_reg == (($past(port_out_reg) & ~$past(out_req.mask))
    | ($past(out_req.data) & $past(out_req.mask)))) else $error("masked write wrong");
  a_out_idle_hold: assert property (out_req.op == pad_port_pkg::OUT_OP_NONE
    |=> $stable(port_out_reg)) else $error("output moved without request");
  a_dir_toggle_bits: assert property (dir_op == pad_port_pkg::DIR_OP_TOGGLE
    |=> port_direction_reg == $past(port_direction_reg ^ dir_bits)) else $error("toggle wrong");
  a_dir_set_bits: assert property (dir_op == pad_port_pkg::DIR_OP_SET
    |=> port_direction_reg == $past(port_direction_reg | dir_bits)) else $error("dir set wrong");
  a_cfg_pin_load: assert property (cfg_we && cfg_pin == 4'h0
    |=> pad_config_block[0][9:2] == $past(cfg_wdata[9:2])) else $error("config load wrong");
  a_pull_none_off: assert property (c0.res_mode == pad_port_pkg::RES_NONE
    |-> !pad_ctl[0].pull_up && !pad_ctl[0].pull_down) else $error("pull on without mode");
  a_repeater_one_pull: assert property (c1.res_mode == pad_port_pkg::RES_REPEATER
    && !deep_power_down |-> pad_ctl[1].pull_up != pad_ctl[1].pull_down)
    else $error("repeater pulls wrong");
  a_deep_pulls_off: assert property (c1.res_mode == pad_port_pkg::RES_REPEATER
    && deep_power_down |-> !pad_ctl[1].pull_up && !pad_ctl[1].pull_down)
    else $error("repeater pulls in deep power down");
  cover property (out_req.op == pad_port_pkg::OUT_OP_MASKED);
  cover property (dir_op == pad_port_pkg::DIR_OP_TOGGLE);
  cover property (c1.res_mode == pad_port_pkg::RES_REPEATER && deep_power_down);
endmodule

bind pad_config_and_gpio_port pad_port_checker pad_port_checker_inst (.clk, .reset, .cfg_we,
  .cfg_pin, .cfg_wdata, .out_req, .dir_op, .dir_bits, .deep_power_down, .periph_out,
  .periph_oe, .pad_out, .pad_oe, .pad_ctl, .port_direction_reg, .port_out_reg,
  .pad_config_block);

// *** verification/board_model.sv ***
// board at the pins: external drivers, pull resistors and floating wires
// assumes the device drive wins; an undriven, unpulled wire wanders every cycle
`timescale 1ns/1ps
module board_model (
  input wire logic clk,
  input wire logic [11:0] pad_out,
  input wire logic [11:0] pad_oe,
  input wire pad_port_pkg::pad_ctl_s [11:0] pad_ctl,
  input wire logic [11:0] ext_en,
  input wire logic [11:0] ext_val,
  output logic [11:0] pad_in
);
  logic [11:0] float_q = 12'h000;
  always @(posedge clk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_ctl[i].pull_up) pad_in[i] = 1'b1;
      else if (pad_ctl[i].pull_down) pad_in[i] = 1'b0;
      else pad_in[i] = float_q[i];
    end
  end
endmodule

// *** verification/pad_config_and_gpio_port_bench.sv ***
// self-checking bench for the pad and port block, board model on the pins
// assumes 25 MHz clk; inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module pad_config_and_gpio_port_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cfg_we = 1'b0;
  logic sink_we = 1'b0;
  logic deep_power_down = 1'b0;
  logic [3:0] cfg_pin = 4'h0;
  logic [3:0] lo = 4'h0;
  logic [3:0] hi = 4'h0;
  logic [11:0] dir_bits = 12'h000, periph_out = 12'h000, periph_oe = 12'h000;
  logic [11:0] ext_en = 12'h000, ext_val = 12'h000;
  logic [11:0] pad_in, pad_out, pad_oe, port_read, port_direction_reg, port_out_reg;
  logic [11:0] periph_in;
  logic [3:0] sink_level;
  pad_port_pkg::pin_cfg_s cfg_wdata = '0;
  pad_port_pkg::out_req_s out_req = '0;
  pad_port_pkg::dir_op_e dir_op = pad_port_pkg::DIR_OP_NONE;
  pad_port_pkg::pad_ctl_s [11:0] pad_ctl;
  pad_port_pkg::pin_cfg_s [11:0] pad_config_block;
  int mismatches = 0;
  int n_checks = 0;
  pad_config_and_gpio_port pad_config_and_gpio_port_inst (.clk, .reset, .cfg_we, .cfg_pin,
    .cfg_wdata, .sink_we, .sink_current_low_level(lo), .sink_current_high_level(hi), .out_req,
    .dir_op, .dir_bits, .deep_power_down, .periph_out, .periph_oe, .pad_in, .pad_out, .pad_oe,
    .pad_ctl, .sink_level, .port_read, .periph_in, .port_direction_reg, .port_out_reg,
    .pad_config_block);
  board_model board_model_inst (.clk, .pad_out, .pad_oe, .pad_ctl, .ext_en, .ext_val, .pad_in);
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic put_out(input pad_port_pkg::out_op_e op, input logic [11:0] d, m);
    @(posedge clk) out_req <= '{op, d, m};
    @(posedge clk) out_req.op <= pad_port_pkg::OUT_OP_NONE;
    #1;
  endtask
  task automatic put_dir(input pad_port_pkg::dir_op_e op, input logic [11:0] b);
    @(posedge clk) begin
      dir_op <= op;
      dir_bits <= b;
    end
    @(posedge clk) dir_op <= pad_port_pkg::DIR_OP_NONE;
    #1;
  endtask
  task automatic put_cfg(input logic [3:0] pin, input pad_port_pkg::pin_cfg_s v);
    @(posedge clk) begin
      cfg_we <= 1'b1;
      cfg_pin <= pin;
      cfg_wdata <= v;
    end
    @(posedge clk) cfg_we <= 1'b0;
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (1000) @(posedge clk);
    mismatches++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK("dir", 12'h000, port_direction_reg)
    `CHK("oe", 12'h000, pad_oe)
    `CHK("cfg0", pad_port_pkg::PIN_CFG_RESET, pad_config_block[0])
    `CHK("cfg4", pad_port_pkg::BUS_CFG_RESET, pad_config_block[4])
    `CHK("cfg10", pad_port_pkg::DEBUG_CFG_RESET, pad_config_block[10])
    `CHK("ctl4", 2'h3, {pad_ctl[4].open_drain, pad_ctl[4].glitch_filter})
    put_out(pad_port_pkg::OUT_OP_WRITE, 12'hA5A, 12'h000);
    `CHK("out", 12'hA5A, port_out_reg)
    put_out(pad_port_pkg::OUT_OP_SET, 12'h101, 12'h000);
    `CHK("out", 12'hB5B, port_out_reg)
    put_out(pad_port_pkg::OUT_OP_CLEAR, 12'h00A, 12'h000);
    `CHK("out", 12'hB51, port_out_reg)
    put_out(pad_port_pkg::OUT_OP_MASKED, 12'h0F0, 12'h0FF);
    `CHK("out", 12'hBF0, port_out_reg)
    put_dir(pad_port_pkg::DIR_OP_SET, 12'h003);
    put_dir(pad_port_pkg::DIR_OP_TOGGLE, 12'h006);
    `CHK("dir", 12'h005, port_direction_reg)
    put_dir(pad_port_pkg::DIR_OP_CLEAR, 12'h004);
    `CHK("dir", 12'h001, port_direction_reg)
    put_out(pad_port_pkg::OUT_OP_SET, 12'h001, 12'h000);
    `CHK("pin0", 2'h3, {pad_oe[0], pad_out[0]})
    @(posedge clk) periph_oe <= 12'h001;
    put_cfg(4'h0, '{pad_port_pkg::PIN_FUNCTION_SELECT_ALT1, pad_port_pkg::RES_NONE, 1'b1, 1'b0, 1'b0, 1'b0,
      1'b0});
    `CHK("pin0", 2'h2, {pad_oe[0], pad_out[0]})
    @(posedge clk) begin
      ext_en <= 12'h002;
      ext_val <= 12'h002;
    end
    repeat (8) @(posedge clk);
    #1;
    `CHK("read1", 1'b1, port_read[1])
    `CHK("pin_in1", 1'b0, periph_in[1])
    put_cfg(4'h1, '{pad_port_pkg::PIN_FUNCTION_SELECT_PORT, pad_port_pkg::RES_REPEATER, 1'b1, 1'b0, 1'b0,
      1'b0, 1'b0});
    @(posedge clk) ext_en <= 12'h000;
    repeat (8) @(posedge clk);
    #1;
    `CHK("read1", 1'b1, port_read[1])
    @(posedge clk) deep_power_down <= 1'b1;
    @(posedge clk) deep_power_down <= 1'b0;
    // high-source pad 7 still holds a port 1 from the masked write; drop it first
    put_out(pad_port_pkg::OUT_OP_CLEAR, 12'h080, 12'h000);
    @(posedge clk) begin
      sink_we <= 1'b1;
      lo <= 4'h3;
      hi <= 4'hC;
    end
    @(posedge clk) sink_we <= 1'b0;
    #1;
    `CHK("sink", 4'h3, sink_level)
    put_dir(pad_port_pkg::DIR_OP_SET, 12'h008);
    put_out(pad_port_pkg::OUT_OP_SET, 12'h008, 12'h000);
    `CHK("sink", 4'hC, sink_level)
    put_cfg(4'h3, '{pad_port_pkg::PIN_FUNCTION_SELECT_PORT, pad_port_pkg::RES_NONE, 1'b1, 1'b0, 1'b0, 1'b0,
      1'b1});
    `CHK("sink3", 2'h1, {pad_oe[3], pad_ctl[3].sink_enable})
    test_done();
  end
endmodule
